// File: clf_consts.svh
// Offsets, field positions, reset values and counts of the clock loop filter and monitor
`ifndef CLF_CONSTS_SVH
`define CLF_CONSTS_SVH

// Register byte addresses
`define CLF_CTRL_OFS 8'h00
`define CLF_CFG_OFS 8'h04
`define CLF_MULT_OFS 8'h08
`define CLF_STATUS_OFS 8'h0c
`define CLF_DCO_OFS 8'h10

// Control fields
`define CLF_CTRL_INT_ON 0
`define CLF_CTRL_EXT_ON 1
`define CLF_CTRL_MON_ON 2

// Configuration option fields
`define CLF_CFG_EXTCLK 0
`define CLF_CFG_XTAL 1
`define CLF_CFG_SLOW 2

// Reset values
`define CLF_CTRL_RST 3'h0
`define CLF_CFG_RST 3'h0
`define CLF_MULT_RST 8'h01
`define CLF_DCO_RST 12'h600

// Oscillator code limits
`define CLF_DIV_SLOWEST 4'h9

// Loop filter corrections, 12-bit two's complement
`define CLF_CORR_N32 12'hfe0
`define CLF_CORR_N8 12'hff8
`define CLF_CORR_N1 12'hfff
`define CLF_CORR_P1 12'h001
`define CLF_CORR_P8 12'h008
`define CLF_CORR_P32 12'h020

// Long divider taps: bit 3 falls after 16 counts, bit 11 after 4096
`define CLF_SETTLE_FAST_BIT 3
`define CLF_SETTLE_SLOW_BIT 11

// Bus responses
`define CLF_RESP_OKAY 2'h0
`define CLF_RESP_SLVERR 2'h2

`endif

// File: clf_pkg.sv
// Types shared by the clock loop filter and monitor
package clf_pkg;

	// Frequency comparator result band of base clock against nominal
	typedef enum logic [2:0] {
		CLF_ERR_LT85 = 3'b000,
		CLF_ERR_LT95 = 3'b001,
		CLF_ERR_LT100 = 3'b010,
		CLF_ERR_LT105 = 3'b011,
		CLF_ERR_LT115 = 3'b100,
		CLF_ERR_GT115 = 3'b101
	} clf_err_band_e;

	// One completed measurement from the comparator
	typedef struct packed {
		logic valid;
		clf_err_band_e band;
	} clf_meas_s;

	// Flags reported to software and the clock switches
	typedef struct packed {
		logic ext_gen_enable;
		logic int_gen_enable;
		logic external_dead;
		logic internal_dead;
		logic external_stable;
		logic internal_stable;
		logic filter_locked;
	} clf_status_s;

	// Oscillator pin enables
	typedef struct packed {
		logic osc_amp_en;
		logic osc_in_port_en;
		logic osc_out_port_en;
	} clf_pins_s;

endpackage : clf_pkg

// File: clf_act_det.sv
// Clock activity detector: counts missed falling edges per reference low phase
`timescale 1ns/1ps
module clf_act_det (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic en_i,
	input wire logic ref_lvl_i,
	input wire logic ref_rise_i,
	input wire logic clk_fall_i,
	output logic dead_o
);
	import clf_pkg::*;

	logic seen_q, seen_d;
	logic miss_q, miss_d;
	logic dead_q, dead_d;
	logic hit;

	assign hit = clk_fall_i & ~ref_lvl_i;

	// Next state; a low phase ends at the reference rising edge
	always_comb begin
		seen_d = seen_q;
		miss_d = miss_q;
		dead_d = dead_q;
		if (!en_i) begin
			seen_d = 1'b0;
			miss_d = 1'b0;
			dead_d = 1'b0;
		end else begin
			if (hit) begin
				seen_d = 1'b1;
				miss_d = 1'b0;
				dead_d = 1'b0; // RULE16 RULE18
			end
			// An edge in the last low cycle still belongs to the ending phase
			if (ref_rise_i) begin
				seen_d = 1'b0;
				if (seen_q || hit) begin
					miss_d = 1'b0;
				end else begin
					miss_d = 1'b1;
					dead_d = miss_q ? 1'b1 : dead_q; // RULE16 RULE18
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			seen_q <= 1'b0;
			miss_q <= 1'b0;
			dead_q <= 1'b0;
		end else begin
			seen_q <= seen_d;
			miss_q <= miss_d;
			dead_q <= dead_d;
		end
	end

	assign dead_o = dead_q;

	chk_dead_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE16
		en_i && hit && !ref_rise_i |=> !dead_o) else $error("dead flag not cleared by edge in low phase");
	chk_dead_two_miss: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE18
		en_i && ref_rise_i && !seen_q && !hit && miss_q |=> dead_o) else $error("dead flag not set after two misses");

endmodule : clf_act_det

// File: clf_top.sv
// Clock generator control: loop filter, pin enables, clock monitor and register slave
`timescale 1ns/1ps
`include "clf_consts.svh"
// Function
// [RULE1] Divider and stage codes form one 12-bit value corrected by error band.
// [RULE2] Corrections are -32, -8, -1, +1, +8, +32 by base clock error band.
// [RULE3] Stage carry increments divider code, borrow decrements it.
// [RULE4] Divider codes A through F act like code 9, the slowest.
// [RULE5] Out-of-range recovery only through normal subtractions; settling above 9FF allowed.
// [RULE6] Filter locked while measured error lies within five percent.
// [RULE7] At most one correction per completed measurement, registered.
// [RULE8] Crystal amplifier enabled only with external enable and crystal option.
// [RULE9] External clock path enabled only while external generator enabled.
// [RULE10] Monitor checks both clocks when on, using base clock as reference source.
// [RULE11] Both clocks divided by four; long divider on one chosen by slow option.
// [RULE12] Long divider held reset whenever external generator disabled.
// [RULE13] Unstable: long divider counts external clock; settle fall sets external stable.
// [RULE14] Stable: divider back to reference duty; losing stability reverts it.
// [RULE15] Software should turn monitor off after inactivity is detected.
// [RULE16] Internal dead after two missed base falls per external reference low phase.
// [RULE17] Internal stable after two locked measurements; cleared by unlock, disable, dead.
// [RULE18] External dead after two missed external falls per internal reference low phase.
// [RULE19] External stable after 4096 or 16 cycles; cleared by disable or dead.
// [RULE20] Internal enable needs on bit and no stop; disabled clocks held low.
// [RULE21] External enable needs on bit and no stop; on bit needs clock option.
// [RULE22] Base clock is internal clock divided by multiplier; 0 or 1 passes through.
module clf_top (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gen_stop_i,
	input wire clf_pkg::clf_meas_s meas_i,
	input wire logic internal_clk_i,
	input wire logic osc_in_pin_i,
	output logic [3:0] dco_divider_code_o,
	output logic [7:0] dco_stage_code_o,
	output logic base_clk_o,
	output logic external_clk_o,
	output logic ext_reference_clk_o,
	output logic int_reference_clk_o,
	output clf_pkg::clf_pins_s pins_o,
	output clf_pkg::clf_status_s status_o
);
	import clf_pkg::*;

	logic [2:0] ctrl_q, ctrl_d;
	logic [2:0] cfg_q, cfg_d;
	logic [7:0] mult_q, mult_d;
	logic int_gen_en, ext_gen_en, mon_on, xtal, slow;
	logic int_dead, ext_dead;

	// Generator enables gated by stop mode; the monitor on bit is not
	assign int_gen_en = ctrl_q[`CLF_CTRL_INT_ON] & ~gen_stop_i; // RULE20
	assign ext_gen_en = ctrl_q[`CLF_CTRL_EXT_ON] & ~gen_stop_i; // RULE21
	assign mon_on = ctrl_q[`CLF_CTRL_MON_ON];
	assign xtal = cfg_q[`CLF_CFG_XTAL];
	assign slow = cfg_q[`CLF_CFG_SLOW];

	// Pin synchronisers: a level counts once stages two and three agree
	logic [1:0] pin_in;
	logic [2:0] sync_q [2];
	logic [1:0] filt_q, filt_d;
	assign pin_in = {osc_in_pin_i, internal_clk_i};
	for (genvar gi = 0; gi < 2; gi++) begin : g_sync
		assign filt_d[gi] = (sync_q[gi][1] == sync_q[gi][2]) ? sync_q[gi][2] : filt_q[gi];
		always_ff @(posedge clk_i) begin
			if (!nrst_i) begin
				sync_q[gi] <= 3'h0;
				filt_q[gi] <= 1'b0;
			end else begin
				sync_q[gi] <= {sync_q[gi][1:0], pin_in[gi]};
				filt_q[gi] <= filt_d[gi];
			end
		end
	end

	// Clock path and monitor state
	logic [7:0] bcnt_q, bcnt_d;
	logic base_q, base_d, ext_q, ext_d;
	logic [1:0] bdiv_q, bdiv_d, ediv_q, ediv_d;
	logic [11:0] long_q, long_d;
	logic int_reference_clk_q, int_reference_clk_d, ext_reference_clk_q, ext_reference_clk_d;
	logic ext_stable_q, ext_stable_d;
	clf_pins_s pins_q, pins_d;
	logic int_rise, base_fall, ext_fall, bdiv_tick, ediv_tick, long_in;
	logic settle_q, settle_d, settle_fall;

	// Next state of dividers, references and external stable flag
	always_comb begin
		int_rise = filt_d[0] & ~filt_q[0];
		bcnt_d = bcnt_q;
		base_d = base_q;
		if (!int_gen_en) begin
			bcnt_d = 8'h00;
			base_d = 1'b0; // RULE20
		end else if (mult_q <= 8'h01) begin
			base_d = filt_d[0]; // RULE22
		end else if (int_rise) begin
			// Wrap also when a smaller factor is written while the count is above it
			bcnt_d = (bcnt_q >= mult_q - 8'h01) ? 8'h00 : bcnt_q + 8'h01; // RULE22
			base_d = (bcnt_d < {1'b0, mult_q[7:1]});
		end
		ext_d = ext_gen_en & filt_d[1]; // RULE9 RULE21
		base_fall = base_q & ~base_d;
		ext_fall = ext_q & ~ext_d;
		// Both clocks always pass a divide by four
		bdiv_d = base_fall ? bdiv_q + 2'h1 : bdiv_q; // RULE11
		ediv_d = !ext_gen_en ? 2'h0 : (ext_fall ? ediv_q + 2'h1 : ediv_q); // RULE11
		bdiv_tick = base_fall & (bdiv_q == 2'h3);
		ediv_tick = ext_fall & (ediv_q == 2'h3);
		// Long divider: settle counter until stable, then reference divider
		long_in = !ext_stable_q ? ext_fall : (slow ? bdiv_tick : ediv_tick); // RULE13 RULE14
		if (!ext_gen_en) begin
			long_d = 12'h000; // RULE12
		end else begin
			long_d = long_in ? long_q + 12'h001 : long_q;
		end
		settle_q = xtal ? long_q[`CLF_SETTLE_SLOW_BIT] : long_q[`CLF_SETTLE_FAST_BIT]; // RULE13
		settle_d = xtal ? long_d[`CLF_SETTLE_SLOW_BIT] : long_d[`CLF_SETTLE_FAST_BIT];
		settle_fall = settle_q & ~settle_d;
		// Later settle edges only re-set an already set flag
		if (!ext_gen_en || ext_dead) begin
			ext_stable_d = 1'b0; // RULE19
		end else begin
			ext_stable_d = settle_fall | ext_stable_q; // RULE13 RULE14 RULE19
		end
		// Slow crystal: long divider on base side so its reference stays slower
		int_reference_clk_d = slow ? long_d[11] : bdiv_d[1]; // RULE10 RULE11
		ext_reference_clk_d = slow ? ediv_d[1] : long_d[11]; // RULE11
		pins_d.osc_amp_en = ext_gen_en & xtal; // RULE8
		pins_d.osc_out_port_en = ~(ext_gen_en & xtal); // RULE8
		pins_d.osc_in_port_en = ~ext_gen_en; // RULE9
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bcnt_q <= 8'h00;
			base_q <= 1'b0;
			ext_q <= 1'b0;
			bdiv_q <= 2'h0;
			ediv_q <= 2'h0;
			long_q <= 12'h000;
			int_reference_clk_q <= 1'b0;
			ext_reference_clk_q <= 1'b0;
			ext_stable_q <= 1'b0;
			pins_q <= 3'b011;
		end else begin
			bcnt_q <= bcnt_d;
			base_q <= base_d;
			ext_q <= ext_d;
			bdiv_q <= bdiv_d;
			ediv_q <= ediv_d;
			long_q <= long_d;
			int_reference_clk_q <= int_reference_clk_d;
			ext_reference_clk_q <= ext_reference_clk_d;
			ext_stable_q <= ext_stable_d;
			pins_q <= pins_d;
		end
	end

	// Activity detectors run only while the monitor is on
	clf_act_det u_int_det (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(mon_on), // RULE10
		.ref_lvl_i(ext_reference_clk_q),
		.ref_rise_i(ext_reference_clk_d & ~ext_reference_clk_q),
		.clk_fall_i(base_fall), // RULE16
		.dead_o(int_dead)
	);
	clf_act_det u_ext_det (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(mon_on), // RULE10
		.ref_lvl_i(int_reference_clk_q),
		.ref_rise_i(int_reference_clk_d & ~int_reference_clk_q),
		.clk_fall_i(ext_fall), // RULE18
		.dead_o(ext_dead)
	);

	// Loop filter state
	logic [11:0] code_q, code_d, corr;
	logic [3:0] div_q, div_d;
	logic locked_q, locked_d, int_stable_q, int_stable_d, in_band;

	// Next code, lock and internal stable; out of range simply wraps into A..F
	always_comb begin
		case (meas_i.band)
			CLF_ERR_LT85: corr = `CLF_CORR_N32; // RULE2
			CLF_ERR_LT95: corr = `CLF_CORR_N8;
			CLF_ERR_LT100: corr = `CLF_CORR_N1;
			CLF_ERR_LT105: corr = `CLF_CORR_P1;
			CLF_ERR_LT115: corr = `CLF_CORR_P8;
			CLF_ERR_GT115: corr = `CLF_CORR_P32;
			default: corr = 12'h000;
		endcase
		in_band = (meas_i.band == CLF_ERR_LT100) || (meas_i.band == CLF_ERR_LT105); // RULE6
		code_d = code_q;
		locked_d = locked_q;
		int_stable_d = int_stable_q;
		if (!int_gen_en) begin
			locked_d = 1'b0;
		end else if (meas_i.valid) begin
			code_d = code_q + corr; // RULE1 RULE3 RULE5 RULE7
			locked_d = in_band; // RULE6
			int_stable_d = int_stable_q | (in_band & locked_q); // RULE17
		end
		if (!int_gen_en || !locked_d || int_dead) begin
			int_stable_d = 1'b0; // RULE17
		end
		div_d = (code_d[11:8] > `CLF_DIV_SLOWEST) ? `CLF_DIV_SLOWEST : code_d[11:8]; // RULE4
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			code_q <= `CLF_DCO_RST;
			div_q <= 4'(`CLF_DCO_RST >> 8);
			locked_q <= 1'b0;
			int_stable_q <= 1'b0;
		end else begin
			code_q <= code_d;
			div_q <= div_d;
			locked_q <= locked_d;
			int_stable_q <= int_stable_d;
		end
	end

	// AXI4-Lite slave state
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0] awa_q, awa_d, wa;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [7:0] ra;
	clf_status_s stat;

	assign stat = '{ext_gen_enable: ext_gen_en, int_gen_enable: int_gen_en, external_dead: ext_dead,
		internal_dead: int_dead, external_stable: ext_stable_q, internal_stable: int_stable_q,
		filter_locked: locked_q};
	assign s_axi_awready = ~aw_q & ~bv_q;
	assign s_axi_wready = ~w_q & ~bv_q;
	assign s_axi_arready = ~rv_q;
	assign wa = {awa_q[7:2], 2'b00};
	assign ra = {s_axi_araddr[7:2], 2'b00};

	// Address and data taken in either order; write done once both are held
	always_comb begin
		aw_d = aw_q;
		awa_d = awa_q;
		w_d = w_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		ctrl_d = ctrl_q;
		cfg_d = cfg_q;
		mult_d = mult_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
		if (aw_q && w_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = `CLF_RESP_OKAY;
			if (wa == `CLF_CTRL_OFS) begin
				if (ws_q[0]) begin
					ctrl_d = wd_q[2:0];
					ctrl_d[`CLF_CTRL_EXT_ON] = wd_q[`CLF_CTRL_EXT_ON] & cfg_q[`CLF_CFG_EXTCLK]; // RULE21
				end
			end else if (wa == `CLF_CFG_OFS) begin
				if (ws_q[0]) cfg_d = wd_q[2:0];
			end else if (wa == `CLF_MULT_OFS) begin
				if (ws_q[0]) mult_d = wd_q[7:0];
			end else if (wa != `CLF_STATUS_OFS && wa != `CLF_DCO_OFS) begin
				br_d = `CLF_RESP_SLVERR;
			end
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rv_d = 1'b1;
			rr_d = `CLF_RESP_OKAY;
			if (ra == `CLF_CTRL_OFS) rd_d = {29'h0, ctrl_q};
			else if (ra == `CLF_CFG_OFS) rd_d = {29'h0, cfg_q};
			else if (ra == `CLF_MULT_OFS) rd_d = {24'h0, mult_q};
			else if (ra == `CLF_STATUS_OFS) rd_d = {25'h0, stat};
			else if (ra == `CLF_DCO_OFS) rd_d = {20'h0, code_q};
			else begin
				rd_d = 32'h0;
				rr_d = `CLF_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bv_q <= 1'b0;
			rv_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			br_q <= 2'h0;
			rd_q <= 32'h0;
			rr_q <= 2'h0;
			ctrl_q <= `CLF_CTRL_RST;
			cfg_q <= `CLF_CFG_RST;
			mult_q <= `CLF_MULT_RST;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			bv_q <= bv_d;
			rv_q <= rv_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			br_q <= br_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
			mult_q <= mult_d;
		end
	end

	// Outputs
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;
	assign dco_divider_code_o = div_q;
	assign dco_stage_code_o = code_q[7:0];
	assign base_clk_o = base_q;
	assign external_clk_o = ext_q;
	assign ext_reference_clk_o = ext_reference_clk_q;
	assign int_reference_clk_o = int_reference_clk_q;
	assign pins_o = pins_q;
	assign status_o = stat;

	chk_corr_down32: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE2
		meas_i.valid && int_gen_en && meas_i.band == CLF_ERR_LT85 |=> code_q == $past(code_q) - 12'h020)
		else $error("correction below 0.85 is not -32");
	chk_corr_up8: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE2
		meas_i.valid && int_gen_en && meas_i.band == CLF_ERR_LT115 |=> code_q == $past(code_q) + 12'h008)
		else $error("correction below 1.15 is not +8");
	chk_stage_carry: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE3
		meas_i.valid && int_gen_en && meas_i.band == CLF_ERR_LT105 && code_q[7:0] == 8'hff
		|=> code_q[11:8] == $past(code_q[11:8]) + 4'h1 && code_q[7:0] == 8'h00)
		else $error("stage carry did not step divider code");
	chk_div_clamp: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
		code_q[11:8] > 4'h9 |-> dco_divider_code_o == 4'h9) else $error("divider code above 9 not held at 9");
	chk_one_corr: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE7
		!meas_i.valid |=> $stable(code_q)) else $error("code moved without a measurement");
	chk_lock_band: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
		meas_i.valid && int_gen_en |=> status_o.filter_locked == $past(in_band)) else $error("lock flag wrong");
	chk_int_stab_clr: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE17
		!int_gen_en || int_dead |=> !status_o.internal_stable) else $error("internal stable not cleared");
	chk_ext_stab_set: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE13
		ext_gen_en && !ext_dead && settle_fall |=> status_o.external_stable) else $error("settle edge missed");
	chk_long_reset: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
		!ext_gen_en |=> long_q == 12'h000 && !status_o.external_stable) else $error("long divider not held");
	chk_amp_enable: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE8
		##1 pins_o.osc_amp_en == $past(ext_gen_en && xtal)) else $error("crystal amplifier enable wrong");
	chk_clocks_low: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE20
		!int_gen_en ##1 !int_gen_en |-> !base_clk_o) else $error("base clock not held low");
	chk_ext_path: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE9
		!ext_gen_en |=> !external_clk_o && pins_o.osc_in_port_en) else $error("external path not disabled");

endmodule : clf_top

// File: clf_ext_src.sv
// External clock source model driving the oscillator input pin
`timescale 1ns/1ps
module clf_ext_src #(
	parameter int HALF_NS = 300
) (
	input wire logic run_i,
	output logic osc_o
);
	logic lvl;

	// Free-running source; a stopped source sits low, as a dead crystal would
	initial begin
		lvl = 1'b0;
		forever begin
			#(HALF_NS);
			lvl = run_i ? ~lvl : 1'b0;
		end
	end

	assign osc_o = lvl;
endmodule : clf_ext_src

// File: test_clf_top.sv
// Self-checking bench for the clock loop filter and monitor
`timescale 1ns/1ps
`include "clf_consts.svh"
module test_clf_top;
	import clf_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i, gen_stop, int_clk, osc_pin, ext_run, prev_lock, lock_m, stab;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, stg_code;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, div_code;
	logic [1:0] bresp, rresp, resp;
	logic base_clk, ext_clk, ext_reference_clk, int_reference_clk;
	logic [11:0] c12;
	clf_meas_s meas;
	clf_pins_s pins;
	clf_status_s st;
	int error_cnt, samples_checked, code_m, seed, n, m, ni, ne;
	int corr[6] = '{-32, -8, -1, 1, 8, 32};
	int mults[4] = '{0, 1, 4, 3};

	clf_top clf_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gen_stop_i(gen_stop),
		.meas_i(meas), .internal_clk_i(int_clk), .osc_in_pin_i(osc_pin), .dco_divider_code_o(div_code),
		.dco_stage_code_o(stg_code), .base_clk_o(base_clk), .external_clk_o(ext_clk),
		.ext_reference_clk_o(ext_reference_clk), .int_reference_clk_o(int_reference_clk), .pins_o(pins), .status_o(st));
	clf_ext_src clf_ext_src_i (.run_i(ext_run), .osc_o(osc_pin));

	// System clock and on-chip oscillator at eight system clock periods, toggling on system clock falling edges
	always #50 clk_i = ~clk_i;
	always #400 int_clk = ~int_clk;

	task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v

	task automatic chk_b(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_b

	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// Address and data offered together, each dropped once taken
	// Response readies stay high, so back to back calls never toggle them in one step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		axi_rd(a, rd, resp);
		chk_v($sformatf("read data %h", a), e, rd);
		chk_v($sformatf("read resp %h", a), er, resp);
	endtask : rd_chk

	// One measurement pulse; while the generator is stopped the model keeps the code and clears the lock
	task automatic do_meas(input int b);
		meas <= '{valid: 1'b1, band: clf_err_band_e'(b)};
		@(posedge clk_i);
		meas <= '{valid: 1'b0, band: clf_err_band_e'(b)};
		if (!gen_stop) begin
			code_m = (code_m + corr[b]) & 32'hfff;
			lock_m = (b == 2 || b == 3);
		end else begin
			lock_m = 1'b0;
		end
		stab = lock_m && prev_lock;
		prev_lock = lock_m;
		c12 = code_m[11:0];
		@(posedge clk_i);
		chk_v("divider code", (c12[11:8] > 4'h9) ? 4'h9 : c12[11:8], div_code);
		chk_v("stage code", c12[7:0], stg_code);
		chk_b("filter locked", lock_m, st.filter_locked);
		chk_b("internal stable", stab, st.internal_stable);
	endtask : do_meas

	task automatic wait_st(input int pos, input int lim, output int cnt);
		cnt = 0;
		while (st[pos] !== 1'b1 && cnt < lim) begin
			@(posedge clk_i);
			cnt++;
		end
	endtask : wait_st

	// Rising edges of base clock, internal and external references over a span
	task automatic count_base(input int span, output int rises, output int irises, output int erises);
		logic [2:0] last;
		rises = 0;
		irises = 0;
		erises = 0;
		last = {base_clk, int_reference_clk, ext_reference_clk};
		repeat (span) begin
			@(posedge clk_i);
			rises += int'(base_clk && !last[2]);
			irises += int'(int_reference_clk && !last[1]);
			erises += int'(ext_reference_clk && !last[0]);
			last = {base_clk, int_reference_clk, ext_reference_clk};
		end
	endtask : count_base

	// Main sequence
	initial begin
		{nrst_i, gen_stop, int_clk, awvalid, wvalid, arvalid} = '0;
		{bready, rready} = 2'b11;
		{awaddr, araddr, wdata, meas, prev_lock} = '0;
		wstrb = 4'hf;
		ext_run = 1'b1;
		seed = 32'h13892bbf;
		code_m = `CLF_DCO_RST;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		chk_v("reset code", {4'h6, 8'h00}, {div_code, stg_code});
		chk_v("reset pins", 3'b011, pins);
		chk_v("reset status", 7'h00, st);
		rd_chk(`CLF_CTRL_OFS, `CLF_CTRL_RST, `CLF_RESP_OKAY);
		rd_chk(`CLF_CFG_OFS, `CLF_CFG_RST, `CLF_RESP_OKAY);
		rd_chk(`CLF_MULT_OFS, `CLF_MULT_RST, `CLF_RESP_OKAY);
		rd_chk(`CLF_DCO_OFS, `CLF_DCO_RST, `CLF_RESP_OKAY);
		rd_chk(8'h14, 32'h0, `CLF_RESP_SLVERR);
		axi_wr(8'h14, 32'h5, resp);
		chk_v("unmapped write", `CLF_RESP_SLVERR, resp);
		axi_wr(`CLF_DCO_OFS, 32'h123, resp);
		rd_chk(`CLF_DCO_OFS, `CLF_DCO_RST, `CLF_RESP_OKAY);
		m = $random(seed);
		axi_wr(`CLF_MULT_OFS, m, resp);
		rd_chk(`CLF_MULT_OFS, m & 32'hff, `CLF_RESP_OKAY);
		axi_wr(`CLF_MULT_OFS, 32'h1, resp);
		// External enable refused without the clock option
		axi_wr(`CLF_CTRL_OFS, 32'h3, resp);
		rd_chk(`CLF_CTRL_OFS, 32'h1, `CLF_RESP_OKAY);
		chk_b("int enable", 1'b1, st.int_gen_enable);
		// Lock pattern, random bands, then a long fall past the bottom code
		foreach (corr[i]) do_meas(i);
		do_meas(2);
		do_meas(3);
		do_meas(3);
		do_meas(4);
		repeat (40) do_meas($unsigned($random(seed)) % 6);
		repeat (60) do_meas(0);
		repeat (4) do_meas(5);
		rd_chk(`CLF_DCO_OFS, code_m, `CLF_RESP_OKAY);
		// Plain clock source: 16 count settle
		axi_wr(`CLF_CFG_OFS, 32'h1, resp);
		axi_wr(`CLF_CTRL_OFS, 32'h3, resp);
		wait_st(2, 200, n);
		chk_b("settle 16", 1'b1, n >= 84 && n <= 112);
		chk_v("pins ext clock", 3'b001, pins);
		axi_wr(`CLF_CTRL_OFS, 32'h1, resp);
		@(posedge clk_i);
		chk_v("ext off", 4'b0010, {st.ext_gen_enable, st.external_stable, pins.osc_in_port_en, ext_clk});
		// Crystal: 4096 count settle from a freshly reset divider
		axi_wr(`CLF_CFG_OFS, 32'h3, resp);
		axi_wr(`CLF_CTRL_OFS, 32'h3, resp);
		@(posedge clk_i);
		chk_v("pins crystal", 3'b100, pins);
		wait_st(2, 30000, n);
		chk_b("settle 4096", 1'b1, n >= 24550 && n <= 24610);
		// Monitor on; then the source dies
		axi_wr(`CLF_CFG_OFS, 32'h1, resp);
		axi_wr(`CLF_CTRL_OFS, 32'h7, resp);
		repeat (300) @(posedge clk_i);
		chk_v("live dead flags", 2'b00, {st.external_dead, st.internal_dead});
		ext_run <= 1'b0;
		wait_st(4, 400, n);
		chk_b("ext dead time", 1'b1, n >= 20 && n <= 200);
		// Stable flag drops one edge after the dead flag
		@(posedge clk_i);
		chk_b("stable lost", 1'b0, st.external_stable);
		axi_wr(`CLF_CTRL_OFS, 32'h3, resp);
		@(posedge clk_i);
		chk_b("dead cleared", 1'b0, st.external_dead);
		ext_run <= 1'b1;
		wait_st(2, 200, n);
		chk_b("resettle", 1'b1, n <= 112);
		// Base clock and reference rates per multiplier; odd passes use the slow option
		foreach (mults[i]) begin
			axi_wr(`CLF_CFG_OFS, (i % 2) ? 32'h5 : 32'h1, resp);
			axi_wr(`CLF_MULT_OFS, mults[i], resp);
			repeat (60) @(posedge clk_i);
			count_base(1600, n, ni, ne);
			m = 200 / ((mults[i] < 2) ? 1 : mults[i]);
			chk_b("base rate", 1'b1, n >= m - 1 && n <= m + 1);
			if (i % 2) begin
				chk_b("ext ref rate", 1'b1, ne >= 65 && ne <= 67);
			end else begin
				chk_b("int ref rate", 1'b1, ni >= m / 4 - 1 && ni <= m / 4 + 1);
			end
		end
		// Stop mode freezes the filter and silences the clocks
		gen_stop <= 1'b1;
		do_meas(5);
		count_base(100, n, ni, ne);
		chk_v("stop base rises", 0, n);
		chk_v("stop ext ref rises", 0, ne);
		chk_v("stop flags", 5'h0, {st.int_gen_enable, st.ext_gen_enable, st.external_stable, ext_clk, base_clk});
		gen_stop <= 1'b0;
		@(posedge clk_i);
		do_meas(3);
		end_sim();
	end

	// Hang guard, well beyond the longest settle wait
	initial begin
		#(80000 * 100);
		error_cnt++;
		end_sim();
	end
endmodule : test_clf_top
